// file: src/ccr_pkg.sv
/*
 Constants for the configuration control register block: bit positions,
 reset values and the unlock key words. Assumes nothing.
*/
package ccr_pkg;
   localparam logic [3:0]  CCR_OFF_CONFIG   = 4'h0;
   localparam logic [3:0]  CCR_OFF_UNLOCK   = 4'h4;
   localparam logic [3:0]  CCR_OFF_STATUS   = 4'h8;
   localparam int          CCR_BIT_PSLOCK   = 13;
   localparam int          CCR_BIT_MDLOCK   = 12;
   localparam int          CCR_BIT_RPFR     = 8;
   localparam int          CCR_BIT_DBGEN    = 3;
   localparam int          CCR_BIT_ONE      = 2;
   localparam int          CCR_BIT_FLASH_ACCESS_ENABLE     = 1;
   localparam int          CCR_BIT_TWOSEL   = 0;
   localparam logic [31:0] CCR_RESET        = 32'h0000_010F;
   localparam logic [31:0] CCR_IMPL_MASK    = 32'h0000_310B;
   localparam logic [31:0] CCR_KEY1         = 32'hAA99_6655;
   localparam logic [31:0] CCR_KEY2         = 32'h5566_99AA;
endpackage : ccr_pkg

// file: src/ccr_sync.sv
/*
 Two flip-flop synchroniser for a level from outside the clock domain.
 Assumes an asynchronous active-low reset.
*/
`timescale 1ns/1ps
module ccr_sync (
   // Clock and reset
   input  wire logic clock,
   input  wire logic nrst,
   // Level
   input  wire logic din,
   output logic      dout
);
   logic meta;

   // First stage feeds only the second
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         meta <= 1'b0;
         dout <= 1'b0;
      end else begin
         meta <= din;
         dout <= meta;
      end
   end
endmodule : ccr_sync

// file: src/ccr_top.sv
/*
 Configuration control register with pin-select and module-disable locks,
 flash access gate and debug port controls. Assumes a single-cycle
 register port on the 125 MHz system clock and test mode entry levels
 arriving from pins.
*/
//
// Behaviour
// - Pin select lock set blocks pin-select writes
// - Module disable lock set blocks its writes
// - Lock bits change only after unlock sequence
// - Reduced power flash bit drives low-power read
// - Debug port enable bit drives debug port
// - Test mode entry clears flash access enable
// - Flash access stalled while enable is zero
// - Two-wire output select chooses TDO use
// - Bits 31 to 14 read zero
// - Bit 2 always reads one
`timescale 1ns/1ps
module ccr_top
   import ccr_pkg::*;
(
   // Clock and reset
   input  wire logic        clock,
   input  wire logic        nrst,
   // Register port
   input  wire logic [3:0]  addr,
   input  wire logic [31:0] wdata,
   input  wire logic        wr,
   input  wire logic        rd,
   output logic      [31:0] rdata,
   // Test mode entry levels from pins
   input  wire logic        serial_programming_mode,
   input  wire logic        scan_test_mode,
   // Guarded register group write requests
   input  wire logic        pin_select_wr_req,
   input  wire logic        module_disable_wr_req,
   output logic             pin_select_wr_en,
   output logic             module_disable_wr_en,
   // Flash access
   input  wire logic        flash_req,
   output logic             flash_stall,
   output logic             flash_grant,
   // Controls
   output logic             reduced_power_flash_read,
   output logic             debug_port_enable,
   output logic             two_wire_output_select
);
   logic [31:0] config_q;
   logic        pin_select_lock;
   logic        module_disable_lock;
   logic        low_power_read;
   logic        debug_enable;
   logic        flash_enable;
   logic        tdo_select;
   logic        unlocked;
   logic        prog_s;
   logic        scan_s;
   logic        test_q;
   logic        test_entry;
   logic        wr_cfg;
   logic        lock_refused;

   function automatic logic [31:0] ccr_view(input logic [31:0] v);
      ccr_view = (v & CCR_IMPL_MASK) | (32'h1 << CCR_BIT_ONE);
   endfunction : ccr_view

   ccr_sync u_sync_prog (
      .clock (clock),
      .nrst  (nrst),
      .din   (serial_programming_mode),
      .dout  (prog_s)
   );

   ccr_sync u_sync_scan (
      .clock (clock),
      .nrst  (nrst),
      .din   (scan_test_mode),
      .dout  (scan_s)
   );

   ccr_unlock u_unlock (
      .clock    (clock),
      .nrst     (nrst),
      .wr_key   (wr && addr == CCR_OFF_UNLOCK),
      .wr_other (wr && addr != CCR_OFF_UNLOCK),
      .wdata    (wdata),
      .unlocked (unlocked)
   );

   assign wr_cfg     = wr && addr == CCR_OFF_CONFIG;
   assign test_entry = (prog_s || scan_s) && !test_q;

   // Rising edge of the OR of the two test modes
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         test_q <= 1'b0;
      end else begin
         test_q <= prog_s || scan_s;
      end
   end

   // Lock bits, only while unlocked
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         pin_select_lock     <= CCR_RESET[CCR_BIT_PSLOCK];
         module_disable_lock <= CCR_RESET[CCR_BIT_MDLOCK];
      end else if (wr_cfg && unlocked) begin
         pin_select_lock     <= wdata[CCR_BIT_PSLOCK];
         module_disable_lock <= wdata[CCR_BIT_MDLOCK];
      end
   end

   // Ordinary control bits
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         low_power_read <= CCR_RESET[CCR_BIT_RPFR];
         debug_enable   <= CCR_RESET[CCR_BIT_DBGEN];
         tdo_select     <= CCR_RESET[CCR_BIT_TWOSEL];
      end else if (wr_cfg) begin
         low_power_read <= wdata[CCR_BIT_RPFR];
         debug_enable   <= wdata[CCR_BIT_DBGEN];
         tdo_select     <= wdata[CCR_BIT_TWOSEL];
      end
   end

   // Hardware clear on test entry beats a software set
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         flash_enable <= CCR_RESET[CCR_BIT_FLASH_ACCESS_ENABLE];
      end else if (test_entry) begin
         flash_enable <= 1'b0;
      end else if (wr_cfg) begin
         flash_enable <= wdata[CCR_BIT_FLASH_ACCESS_ENABLE];
      end
   end

   // Word view of the stored bits; one driver per bit, the rest zero
   always_comb begin
      config_q                 = 32'h0;
      config_q[CCR_BIT_PSLOCK] = pin_select_lock;
      config_q[CCR_BIT_MDLOCK] = module_disable_lock;
      config_q[CCR_BIT_RPFR]   = low_power_read;
      config_q[CCR_BIT_DBGEN]  = debug_enable;
      config_q[CCR_BIT_FLASH_ACCESS_ENABLE]   = flash_enable;
      config_q[CCR_BIT_TWOSEL] = tdo_select;
   end

   // Sticky record of a lock-bit write refused for want of unlock
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         lock_refused <= 1'b0;
      end else if (wr_cfg && !unlocked
                   && (wdata[CCR_BIT_PSLOCK] != config_q[CCR_BIT_PSLOCK]
                   || wdata[CCR_BIT_MDLOCK] != config_q[CCR_BIT_MDLOCK])) begin
         lock_refused <= 1'b1;
      end else if (rd && addr == CCR_OFF_STATUS) begin
         lock_refused <= 1'b0;
      end
   end

   // Read data valid only the cycle after the strobe
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         rdata <= 32'h0;
      end else if (rd) begin
         case (addr)
            CCR_OFF_CONFIG: rdata <= ccr_view(config_q);
            CCR_OFF_UNLOCK: rdata <= {31'h0, unlocked};
            CCR_OFF_STATUS: rdata <= {28'h0, lock_refused, test_q,
                                      scan_s, prog_s};
            default:        rdata <= 32'h0;
         endcase
      end else begin
         rdata <= 32'h0;
      end
   end

   // Guarded group writes
   assign pin_select_wr_en     = pin_select_wr_req
                                 && !config_q[CCR_BIT_PSLOCK];
   assign module_disable_wr_en = module_disable_wr_req
                                 && !config_q[CCR_BIT_MDLOCK];

   // Flash gate: a stalled initiator simply waits for the bit
   assign flash_stall = flash_req && !config_q[CCR_BIT_FLASH_ACCESS_ENABLE];
   assign flash_grant = flash_req && config_q[CCR_BIT_FLASH_ACCESS_ENABLE];

   assign reduced_power_flash_read = config_q[CCR_BIT_RPFR];
   assign debug_port_enable        = config_q[CCR_BIT_DBGEN];
   assign two_wire_output_select   = config_q[CCR_BIT_TWOSEL];
endmodule : ccr_top

// file: src/ccr_unlock.sv
/*
 System unlock sequencer: two key words written in consecutive writes to
 the unlock offset open the lock bits; any later write to the unlock offset closes them again.
 Assumes register-port strobes on the same clock.
*/
`timescale 1ns/1ps
module ccr_unlock
   import ccr_pkg::*;
(
   // Clock and reset
   input  wire logic        clock,
   input  wire logic        nrst,
   // Write port
   input  wire logic        wr_key,
   input  wire logic        wr_other,
   input  wire logic [31:0] wdata,
   // State
   output logic             unlocked
);
   typedef enum {CCR_IDLE, CCR_HALF, CCR_OPEN} ccr_unlock_e;
   ccr_unlock_e state;

   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         state <= CCR_IDLE;
      end else begin
         case (state)
            CCR_IDLE: begin
               if (wr_key && wdata == CCR_KEY1) state <= CCR_HALF;
            end
            CCR_HALF: begin
               if (wr_key && wdata == CCR_KEY2) state <= CCR_OPEN;
               else if (wr_key || wr_other) state <= CCR_IDLE;
            end
            CCR_OPEN: begin
               // Stays open until software writes any word to the unlock offset
               if (wr_key) state <= (wdata == CCR_KEY1) ? CCR_HALF
                                                        : CCR_IDLE;
            end
            default: state <= CCR_IDLE;
         endcase
      end
   end

   assign unlocked = (state == CCR_OPEN);
endmodule : ccr_unlock

// file: test/ccr_chk.sv
/* Port checker for ccr_top.
 Assumes it is bound to every ccr_top instance. */
`timescale 1ns/1ps
module ccr_chk
   import ccr_pkg::*;
(
   // Clock and reset
   input wire logic        clock,
   input wire logic        nrst,
   // Register port
   input wire logic [3:0]  addr,
   input wire logic        rd,
   input wire logic [31:0] rdata,
   // Pins, groups, flash, controls
   input wire logic        serial_programming_mode,
   input wire logic        scan_test_mode,
   input wire logic        pin_select_wr_req,
   input wire logic        module_disable_wr_req,
   input wire logic        pin_select_wr_en,
   input wire logic        module_disable_wr_en,
   input wire logic        flash_req,
   input wire logic        flash_stall,
   input wire logic        flash_grant,
   input wire logic        reduced_power_flash_read,
   input wire logic        debug_port_enable,
   input wire logic        two_wire_output_select
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (!nrst);
   // Locks are not ports, so config read data stands in for them
   logic cfg_rd;
   always_ff @(posedge clock or negedge nrst)
      if (!nrst)
         cfg_rd <= 1'b0;
      else
         cfg_rd <= rd && addr == CCR_OFF_CONFIG;
   sequence s_entry;
      $rose(serial_programming_mode || scan_test_mode) ##3 flash_req;
   endsequence
   chk_ps_gate: assert property (
      cfg_rd && pin_select_wr_req |->
      pin_select_wr_en == !rdata[CCR_BIT_PSLOCK]) else $error("pin gate");
   chk_md_gate: assert property (
      cfg_rd && module_disable_wr_req |->
      module_disable_wr_en == !rdata[CCR_BIT_MDLOCK]) else $error("md gate");
   chk_flash_pair: assert property (
      (flash_stall || flash_grant) == flash_req &&
      !(flash_stall && flash_grant)) else $error("flash pair");
   chk_flash_bit: assert property (
      cfg_rd && flash_req |-> flash_grant == rdata[CCR_BIT_FLASH_ACCESS_ENABLE])
      else $error("flash grant");
   chk_test_clear: assert property (
      s_entry |-> !flash_grant) else $error("test entry");
   chk_ctrl_bits: assert property (
      cfg_rd |-> {reduced_power_flash_read, debug_port_enable,
      two_wire_output_select} == {rdata[CCR_BIT_RPFR],
      rdata[CCR_BIT_DBGEN], rdata[CCR_BIT_TWOSEL]}) else $error("ctrl");
   chk_fixed_bits: assert property (
      cfg_rd |-> rdata[CCR_BIT_ONE] && rdata[11:9] == 3'h0 &&
      rdata[7:4] == 4'h0) else $error("fixed bits");
   chk_upper_zero: assert property (
      rdata[31:14] == 18'h0) else $error("upper bits");
   chk_rd_idle: assert property (
      !$past(rd) |-> rdata == 32'h0) else $error("idle read data");
endmodule : ccr_chk
bind ccr_top ccr_chk i_ccr_chk (.clock, .nrst, .addr, .rd, .rdata,
   .serial_programming_mode, .scan_test_mode, .pin_select_wr_req,
   .module_disable_wr_req, .pin_select_wr_en, .module_disable_wr_en,
   .flash_req, .flash_stall, .flash_grant, .reduced_power_flash_read,
   .debug_port_enable, .two_wire_output_select);

// file: test/ccr_top_test.sv
/* Bench for ccr_top over its register port and pins.
 Assumes the checker binds itself. */
`timescale 1ns/1ps
module ccr_top_test
   import ccr_pkg::*;
;
   logic clock = 1'b0, nrst = 1'b0, wr = 1'b0, rd = 1'b0;
   logic [3:0] addr = 4'h0;
   logic [31:0] wdata = 32'h0, rdata;
   logic serial_programming_mode = 1'b0, scan_test_mode = 1'b0;
   logic pin_select_wr_req = 1'b1, module_disable_wr_req = 1'b1;
   logic flash_req = 1'b1, pin_select_wr_en, module_disable_wr_en;
   logic flash_stall, flash_grant, reduced_power_flash_read;
   logic debug_port_enable, two_wire_output_select;
   int n_mismatch = 0, n_checks = 0, cyc = 0;
   always #4 clock = ~clock;
   ccr_top i_ccr_top (.clock, .nrst, .addr, .wdata, .wr, .rd, .rdata,
      .serial_programming_mode, .scan_test_mode, .pin_select_wr_req,
      .module_disable_wr_req, .pin_select_wr_en, .module_disable_wr_en,
      .flash_req, .flash_stall, .flash_grant, .reduced_power_flash_read,
      .debug_port_enable, .two_wire_output_select);
   task automatic cmp_val(input logic [31:0] got, input logic [31:0] e);
      n_checks++;
      if (got !== e) begin
         n_mismatch++;
         $display("[ERR] %0t got %h expected %h", $time, got, e);
      end
   endtask : cmp_val
   task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
      @(posedge clock);
      wr <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge clock);
      wr <= 1'b0;
   endtask : wr_reg
   task automatic rd_reg(input logic [3:0] a, input logic [31:0] e);
      @(posedge clock);
      rd <= 1'b1;
      addr <= a;
      @(posedge clock);
      rd <= 1'b0;
      #1 cmp_val(rdata, e);
   endtask : rd_reg
   // Order: pin enable, module enable, grant, stall
   task automatic req_chk(input logic [3:0] e);
      @(posedge clock);
      #1 cmp_val({pin_select_wr_en, module_disable_wr_en, flash_grant,
         flash_stall}, {28'h0, e});
   endtask : req_chk
   task automatic unlock;
      wr_reg(CCR_OFF_UNLOCK, CCR_KEY1);
      wr_reg(CCR_OFF_UNLOCK, CCR_KEY2);
   endtask : unlock
   task automatic t_reset;
      rd_reg(CCR_OFF_CONFIG, 32'h0000_010F);
      rd_reg(4'hC, 32'h0);
      req_chk(4'b1110);
      cmp_val({29'h0, reduced_power_flash_read, debug_port_enable,
         two_wire_output_select}, 32'h7);
      $display("test reset done");
   endtask : t_reset
   task automatic t_fields;
      wr_reg(CCR_OFF_CONFIG, 32'hFFFF_FFFF);
      rd_reg(CCR_OFF_CONFIG, 32'h0000_010F);
      rd_reg(CCR_OFF_STATUS, 32'h0000_0008);
      rd_reg(CCR_OFF_STATUS, 32'h0000_0000);
      wr_reg(CCR_OFF_CONFIG, 32'h0);
      rd_reg(CCR_OFF_CONFIG, 32'h0000_0004);
      cmp_val({reduced_power_flash_read, debug_port_enable,
         two_wire_output_select}, 32'h0);
      req_chk(4'b1101);
      $display("test fields done");
   endtask : t_fields
   task automatic t_locks;
      unlock();
      rd_reg(CCR_OFF_UNLOCK, 32'h0000_0001);
      wr_reg(CCR_OFF_CONFIG, 32'h0000_3000);
      rd_reg(CCR_OFF_CONFIG, 32'h0000_3004);
      req_chk(4'b0001);
      wr_reg(CCR_OFF_UNLOCK, 32'h0);
      wr_reg(CCR_OFF_CONFIG, 32'h0);
      rd_reg(CCR_OFF_CONFIG, 32'h0000_3004);
      unlock();
      wr_reg(CCR_OFF_CONFIG, 32'h0000_2002);
      rd_reg(CCR_OFF_CONFIG, 32'h0000_2006);
      req_chk(4'b0110);
      $display("test locks done");
   endtask : t_locks
   // Pins idle between entries so the synced OR sees a fresh rise
   task automatic t_test;
      for (int i = 0; i < 2; i++) begin
         repeat (4) @(posedge clock);
         if (i == 0)
            serial_programming_mode <= 1'b1;
         else
            scan_test_mode <= 1'b1;
         repeat (4) @(posedge clock);
         rd_reg(CCR_OFF_CONFIG, 32'h0000_2004);
         req_chk(4'b0101);
         rd_reg(CCR_OFF_STATUS, (i == 0) ? 32'hD : 32'h6);
         serial_programming_mode <= 1'b0;
         scan_test_mode <= 1'b0;
         wr_reg(CCR_OFF_CONFIG, 32'h0000_2002);
         rd_reg(CCR_OFF_CONFIG, 32'h0000_2006);
      end
      $display("test mode entry done");
   endtask : t_test
   task automatic conclude;
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : conclude
   always @(posedge clock) begin
      cyc++;
      if (cyc == 2000) begin
         n_mismatch++;
         conclude();
      end
   end
   initial begin
      repeat (12) @(posedge clock);
      nrst <= 1'b1;
      t_reset();
      t_fields();
      t_locks();
      t_test();
      conclude();
   end
endmodule : ccr_top_test
